// >>> mac_ctrl.sv
/*
  controller end: splits read, write and mode-set commands over two edges in multiplexed mode
  and keeps row-cycle spacing per bank. assumes the user holds a request
  until accepted.
*/
`default_nettype none
module mac_ctrl
  import mac_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  // user request
  input  wire logic                 req_in,
  input  wire mac_cmd_t             req_cmd_in,
  input  wire logic [BANK_W-1:0]    req_bank_in,
  input  wire logic [LADDR_W-1:0]   req_addr_in,
  input  wire mac_bl_t              bl_in,
  input  wire logic [CFG_W-1:0]     cfg_in,
  output logic                      ack_out,
  output logic                      bl_illegal_out,
  // link
  mac_if.ctrl                       link
);
  ////////////////////////////////////////////////////////////////////////
  localparam int NBANK = 1 << BANK_W;
  logic                   mux_reg;
  logic                   second_reg;
  logic [LADDR_W-1:0]     addr_reg;
  logic [LAT_W-1:0]       busy_reg [0:NBANK-1];
  logic [CFG_W-1:0]       cfg_sel;
  logic [LAT_W-1:0]       trc;
  logic                   bl_bad;
  logic                   accept;
  logic [BALL_W-1:0]      first_balls;
  logic [BALL_W-1:0]      second_balls;

  assign cfg_sel = (cfg_in >= 3'h1 && cfg_in <= 3'h5) ? cfg_in : 3'h1;
  assign trc     = TRC_TAB[cfg_sel];
  assign bl_bad  = (bl_in == MAC_BL8) && (cfg_sel == 3'h1 || cfg_sel == 3'h4);
  // a request waits for its bank's row cycle; a held request is still up while
  // ack_out stands, so that cycle never takes it twice (one idle clock per request)
  assign accept  = req_in && !ack_out && !second_reg && !bl_bad && req_cmd_in != MAC_NOP
                   && busy_reg[req_bank_in] == '0;

  always_comb begin
    first_balls = '0;
    second_balls = '0;
    for (int i = 0; i < BALL_W; i++) begin
      first_balls[i] = req_addr_in[i];
    end
    second_balls[3]  = addr_reg[1];
    second_balls[4]  = addr_reg[2];
    second_balls[8]  = addr_reg[6];
    second_balls[9]  = addr_reg[7];
    second_balls[10] = addr_reg[19];
    second_balls[13] = addr_reg[11];
    second_balls[14] = addr_reg[12];
    second_balls[17] = addr_reg[16];
    second_balls[18] = addr_reg[15];
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link.cmd       <= MAC_NOP;
      link.bank      <= '0;
      link.ball      <= '0;
      second_reg     <= 1'b0;
      addr_reg       <= '0;
      ack_out        <= 1'b0;
      bl_illegal_out <= 1'b0;
    end else begin
      bl_illegal_out <= bl_bad;
      ack_out        <= accept;
      if (second_reg) begin
        link.cmd   <= MAC_NOP;
        link.ball  <= second_balls;
        second_reg <= 1'b0;
      end else if (accept) begin
        link.cmd  <= req_cmd_in;
        link.bank <= req_bank_in;
        link.ball <= first_balls;
        addr_reg  <= req_addr_in;
        // refresh carries bank only, so the next clock is free
        second_reg <= mux_reg && req_cmd_in != MAC_AUTO_REFRESH_CMD;
      end else begin
        link.cmd <= MAC_NOP;
      end
    end
  end

  // own copy of the device's multiplexed mode bit
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mux_reg <= 1'b0;
    end else if (accept && req_cmd_in == MAC_MRS) begin
      mux_reg <= req_addr_in[MRS_MUX_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int b = 0; b < NBANK; b++) begin
        busy_reg[b] <= '0;
      end
    end else begin
      for (int b = 0; b < NBANK; b++) begin
        if (accept && req_bank_in == b[BANK_W-1:0] && req_cmd_in != MAC_MRS) begin
          busy_reg[b]    <= (req_cmd_in == MAC_WRITE && cfg_sel == CFG_SHORT_TRC[CFG_W-1:0])
                            ? TRC_WR_RD_CFG4 - 4'h1 : trc - 4'h1;
        end else if (busy_reg[b] != '0) begin
          busy_reg[b] <= busy_reg[b] - 4'h1;
        end
      end
    end
  end
endmodule // mac_ctrl
`default_nettype wire

// >>> mac_dev.sv
/*
  device end: captures split addresses and issues decoded commands.
  assumes the controller keeps the command spacing of the far side.
*/
// What this block does
// - first edge passes balls A0, A3-A5, A8-A10, A13, A14, A17, A18 same-named
// - BL2 second edge remaps balls, ignores A0,A5
// - BL4/8 second edge ignores ball A10; BL8 first edge ignores A18
// - multiplexed mode adds one latency clock
// - configurations set row cycle, latencies, frequency
// - controller avoids BL8 in configurations 1,4
// - configuration 4 row cycle 3, write-read 4
// - refresh executes next edge, bank only
// - command may follow refresh next clock
// - mode bit A5 enables multiplexed addressing
// - address in two parts, consecutive edges
// - bank sampled only with first part
// - controller waits row cycle after refresh
`default_nettype none
module mac_dev
  import mac_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  // link
  mac_if.dev                        link,
  // settings held by the device
  input  wire mac_bl_t              bl_in,
  input  wire logic [CFG_W-1:0]     cfg_in,
  // decoded command
  output logic                      cmd_valid_out,
  output mac_cmd_t                  cmd_out,
  output logic [BANK_W-1:0]         bank_out,
  output logic [LADDR_W-1:0]        addr_out,
  output logic [LAT_W-1:0]          read_latency_out,
  output logic [LAT_W-1:0]          write_latency_out,
  output logic [LAT_W-1:0]          row_cycle_out,
  output logic                      mux_mode_out
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic {MAC_FIRST, MAC_SECOND} mac_phase_t;
  mac_phase_t            phase_reg;
  mac_cmd_t              pend_cmd_reg;
  logic [BANK_W-1:0]     pend_bank_reg;
  logic [LADDR_W-1:0]    first_addr_part_reg;
  logic [LADDR_W-1:0]    second_addr_part;
  logic [LADDR_W-1:0]    first_map;
  logic                  mux_reg;
  logic [CFG_W-1:0]      cfg_sel;

  assign cfg_sel = (cfg_in >= 3'h1 && cfg_in <= 3'h5) ? cfg_in : 3'h1;

  // first edge: same-named balls
  always_comb begin
    first_map = '0;
    first_map[0]  = link.ball[0];
    first_map[3]  = link.ball[3];
    first_map[4]  = link.ball[4];
    first_map[5]  = link.ball[5];
    first_map[8]  = link.ball[8];
    first_map[9]  = link.ball[9];
    first_map[10] = link.ball[10];
    first_map[13] = link.ball[13];
    first_map[14] = link.ball[14];
    first_map[17] = link.ball[17];
    first_map[18] = (bl_in == MAC_BL8) ? 1'b0 : link.ball[18];
  end

  // second edge: remapped balls, A0 and A5 ignored
  always_comb begin
    second_addr_part = '0;
    second_addr_part[1]  = link.ball[3];
    second_addr_part[2]  = link.ball[4];
    second_addr_part[6]  = link.ball[8];
    second_addr_part[7]  = link.ball[9];
    second_addr_part[19] = (bl_in == MAC_BL2) ? link.ball[10] : 1'b0;
    second_addr_part[11] = link.ball[13];
    second_addr_part[12] = link.ball[14];
    second_addr_part[16] = link.ball[17];
    second_addr_part[15] = link.ball[18];
  end

  ////////////////////////////////////////////////////////////////////////
  // capture sequencing; non-multiplexed commands complete in one edge
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_reg           <= MAC_FIRST;
      pend_cmd_reg        <= MAC_NOP;
      pend_bank_reg       <= '0;
      first_addr_part_reg <= '0;
    end else begin
      unique case (phase_reg)
        MAC_FIRST: begin
          if (mux_reg && (link.cmd == MAC_READ || link.cmd == MAC_WRITE
                          || link.cmd == MAC_MRS)) begin
            phase_reg           <= MAC_SECOND;
            pend_cmd_reg        <= link.cmd;
            pend_bank_reg       <= link.bank;
            first_addr_part_reg <= first_map;
          end
        end
        MAC_SECOND: begin
          // the command input is not looked at here: this clock is address only
          phase_reg <= MAC_FIRST;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_valid_out <= 1'b0;
      cmd_out       <= MAC_NOP;
      bank_out      <= '0;
      addr_out      <= '0;
    end else if (phase_reg == MAC_SECOND) begin
      cmd_valid_out <= 1'b1;
      cmd_out       <= pend_cmd_reg;
      bank_out      <= pend_bank_reg;
      addr_out      <= first_addr_part_reg | second_addr_part;
    end else if (link.cmd == MAC_AUTO_REFRESH_CMD) begin
      // refresh needs the bank only, so it goes out after one edge
      cmd_valid_out <= 1'b1;
      cmd_out       <= MAC_AUTO_REFRESH_CMD;
      bank_out      <= link.bank;
      addr_out      <= '0;
    end else if (!mux_reg && link.cmd != MAC_NOP) begin
      cmd_valid_out <= 1'b1;
      cmd_out       <= link.cmd;
      bank_out      <= link.bank;
      addr_out      <= {1'b0, link.ball};
    end else begin
      cmd_valid_out <= 1'b0;
      cmd_out       <= MAC_NOP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode bit is taken from the completed mode-register set
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mux_reg <= 1'b0;
    end else if (phase_reg == MAC_SECOND && pend_cmd_reg == MAC_MRS) begin
      mux_reg <= first_addr_part_reg[MRS_MUX_BIT];
    end else if (phase_reg == MAC_FIRST && !mux_reg && link.cmd == MAC_MRS) begin
      mux_reg <= link.ball[MRS_MUX_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mux_mode_out      <= 1'b0;
      read_latency_out  <= '0;
      write_latency_out <= '0;
      row_cycle_out     <= '0;
    end else begin
      mux_mode_out <= mux_reg;
      // tables hold multiplexed figures; plain mode is one clock less
      read_latency_out  <= mux_reg ? RL_TAB[cfg_sel]
                                   : RL_TAB[cfg_sel] - MUX_EXTRA;
      write_latency_out <= mux_reg ? WL_TAB[cfg_sel]
                                   : WL_TAB[cfg_sel] - MUX_EXTRA;
      row_cycle_out     <= TRC_TAB[cfg_sel];
    end
  end
endmodule // mac_dev
`default_nettype wire

// >>> mac_if.sv
/*
  link between memory controller and device command port.
  assumes both ends share clk_in.
*/
`default_nettype none
interface mac_if;
  import mac_pkg::*;
  mac_cmd_t                   cmd;
  logic [BANK_W-1:0]          bank;
  logic [mac_pkg::BALL_W-1:0] ball;
  modport ctrl (output cmd, output bank, output ball);
  modport dev  (input cmd, input bank, input ball);
endinterface
`default_nettype wire

// >>> mac_monitor.sv
/*
  link checker for the command port.
  assumes one clock, link and device outputs wired in by name.
*/
`default_nettype none
module mac_monitor
  import mac_pkg::*;
(
  // clock and reset
  input wire logic               clk_in,
  input wire logic               nrst_in,
  // link
  input wire mac_cmd_t           cmd,
  input wire logic [BANK_W-1:0]  bank,
  input wire logic [BALL_W-1:0]  ball,
  // device side
  input wire logic [CFG_W-1:0]   cfg_in,
  input wire logic               cmd_valid_out,
  input wire mac_cmd_t           cmd_out,
  input wire logic [BANK_W-1:0]  bank_out,
  input wire logic [LAT_W-1:0]   read_latency_out,
  input wire logic [LAT_W-1:0]   write_latency_out,
  input wire logic [LAT_W-1:0]   row_cycle_out,
  input wire logic               mux_mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic second_reg;
  logic split;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////////////////
  // second part cycles never start a command, so track them here
  assign split = !second_reg && mux_mode_out && (cmd inside {MAC_READ, MAC_WRITE, MAC_MRS});
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      second_reg <= 1'b0;
    end else begin
      second_reg <= split;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence split_start; split; endsequence
  sequence answer_two;
    ##2 cmd_valid_out && cmd_out == $past(cmd, 2) && bank_out == $past(bank, 2);
  endsequence
  // latencies follow settings one cycle late, so only judge settled values
  sequence steady;
    $stable(cfg_in) && $stable(mux_mode_out) && cfg_in inside {[1:5]};
  endsequence
  a_gap_after_split: assert property (split_start |=> cmd == MAC_NOP)
    else $error("command in second part cycle");
  a_split_answer: assert property (split_start |-> answer_two)
    else $error("split command not decoded two cycles later");
  a_refresh_next_edge: assert property (!second_reg && cmd == MAC_AUTO_REFRESH_CMD |=>
    cmd_valid_out && cmd_out == MAC_AUTO_REFRESH_CMD) else $error("refresh not decoded next cycle");
  a_mode_bit_on: assert property (!second_reg && cmd == MAC_MRS && ball[MRS_MUX_BIT]
    |-> ##[1:3] mux_mode_out) else $error("mode bit did not enable split addressing");
  a_read_lat_mux: assert property (steady ##0 mux_mode_out |->
    read_latency_out == RL_TAB[cfg_in]) else $error("read latency wrong");
  a_write_lat_mux: assert property (steady ##0 mux_mode_out |->
    write_latency_out == WL_TAB[cfg_in]) else $error("write latency wrong");
  a_row_cycle_cfg: assert property (steady |-> row_cycle_out == TRC_TAB[cfg_in])
    else $error("row cycle wrong");
  a_lat_extra_clk: assert property (steady ##0 !mux_mode_out |->
    read_latency_out == RL_TAB[cfg_in] - MUX_EXTRA) else $error("plain latency wrong");
endmodule // mac_monitor
`default_nettype wire

// >>> mac_pkg.sv
/*
  shared constants for the multiplexed-address command port: commands,
  ball positions, per-configuration latencies and row-cycle figures.
  assumes a single 25 MHz clock and an active-low asynchronous reset.
*/
`default_nettype none
package mac_pkg;
  localparam int BALL_W   = 19;
  localparam int LADDR_W  = 20;
  localparam int BANK_W   = 3;
  localparam int CFG_W    = 3;
  localparam int LAT_W    = 4;

  typedef enum logic [2:0] {
    MAC_NOP, MAC_READ, MAC_WRITE, MAC_MRS, MAC_AUTO_REFRESH_CMD
  } mac_cmd_t;

  typedef enum logic [1:0] {MAC_BL2, MAC_BL4, MAC_BL8} mac_bl_t;

  // mode-register bit that turns on multiplexed addressing
  localparam int MRS_MUX_BIT = 5;

  // latency added by multiplexed addressing
  localparam logic [LAT_W-1:0] MUX_EXTRA = 4'h1;

  // per configuration 1..5, index 0 unused
  localparam logic [LAT_W-1:0] TRC_TAB [0:5] = '{4'h0, 4'h4, 4'h6, 4'h8, 4'h3, 4'h5};
  localparam logic [LAT_W-1:0] RL_TAB  [0:5] = '{4'h0, 4'h5, 4'h7, 4'h9, 4'h4, 4'h6};
  localparam logic [LAT_W-1:0] WL_TAB  [0:5] = '{4'h0, 4'h6, 4'h8, 4'hA, 4'h5, 4'h7};
  localparam int FMAX_MHZ [0:5] = '{0, 266, 400, 533, 200, 333};
  localparam int FMIN_MHZ = 175;
  // write followed by read to one bank in configuration 4
  localparam logic [LAT_W-1:0] TRC_WR_RD_CFG4 = 4'h4;
  localparam int CFG_SHORT_TRC = 4;
endpackage
`default_nettype wire

// >>> testbench.sv
/*
  bench joining controller and device ends with a queue model.
  assumes the package tables and a 25 MHz clock.
*/
`default_nettype none
module testbench import mac_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, nrst_in, req_in, ack_out, bl_illegal_out, cmd_valid_out, mux_mode_out, mux_m;
  mac_cmd_t req_cmd_in, cmd_out;
  mac_bl_t bl_in;
  logic [BANK_W-1:0] req_bank_in, bank_out;
  logic [LADDR_W-1:0] req_addr_in, addr_out;
  logic [CFG_W-1:0] cfg_in;
  logic [LAT_W-1:0] read_latency_out, write_latency_out, row_cycle_out;
  logic [45:0] exp_q[$];
  logic [15:0] lfsr_reg = 16'h51F2;
  int n_mismatch = 0, checked = 0, cyc = 0;
  int rl_t[6] = '{0, 5, 7, 9, 4, 6}, wl_t[6] = '{0, 6, 8, 10, 5, 7}, rc_t[6] = '{0, 4, 6, 8, 3, 5};
  int last_t[8] = '{default: -100};
  mac_cmd_t last_c[8] = '{default: MAC_NOP};
  mac_if lk();
  mac_ctrl u_mac_ctrl (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req_in),
    .req_cmd_in(req_cmd_in), .req_bank_in(req_bank_in), .req_addr_in(req_addr_in),
    .bl_in(bl_in), .cfg_in(cfg_in), .ack_out(ack_out), .bl_illegal_out(bl_illegal_out),
    .link(lk.ctrl));
  mac_dev u_mac_dev (.clk_in(clk_in), .nrst_in(nrst_in), .link(lk.dev), .bl_in(bl_in),
    .cfg_in(cfg_in), .cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out), .bank_out(bank_out),
    .addr_out(addr_out), .read_latency_out(read_latency_out),
    .write_latency_out(write_latency_out), .row_cycle_out(row_cycle_out),
    .mux_mode_out(mux_mode_out));
  mac_monitor u_mac_monitor (.clk_in(clk_in), .nrst_in(nrst_in), .cmd(lk.cmd), .bank(lk.bank),
    .ball(lk.ball), .cfg_in(cfg_in), .cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out),
    .bank_out(bank_out), .read_latency_out(read_latency_out),
    .write_latency_out(write_latency_out), .row_cycle_out(row_cycle_out),
    .mux_mode_out(mux_mode_out));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt();
    lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    return lfsr_reg;
  endfunction
  task automatic chk(string nm, logic [19:0] e, logic [19:0] s);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // request stays up into the next call so back-to-back commands keep req_in high
  task automatic issue(mac_cmd_t c, logic [2:0] b, logic [19:0] a);
    logic [19:0] m;
    int n;
    m = (c == MAC_AUTO_REFRESH_CMD) ? 20'h00000 : !mux_m ? 20'h7FFFF :
        (bl_in == MAC_BL2) ? 20'hFFFFF : (bl_in == MAC_BL4) ? 20'h7FFFF : 20'h3FFFF;
    req_in <= 1'b1;
    req_cmd_in <= c;
    req_bank_in <= b;
    req_addr_in <= a;
    exp_q.push_back({m, c, b, a & m});
    if (c == MAC_MRS) mux_m = a[MRS_MUX_BIT];
    n = 0;
    do begin @(posedge clk_in); n++; end while (ack_out !== 1'b1 && n < 40);
    chk("ack", 20'h1, {19'h0, ack_out});
  endtask
  // a second address part may still be on the link: let it land before the mode changes
  task automatic setup(int c, mac_bl_t b);
    req_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    cfg_in <= c[2:0];
    bl_in <= b;
    repeat (10) @(posedge clk_in);
    chk("rl", rl_t[c] - (mux_m ? 0 : 1), read_latency_out);
    chk("wl", wl_t[c] - (mux_m ? 0 : 1), write_latency_out);
    chk("rc", rc_t[c], row_cycle_out);
    chk("mux", mux_m, mux_mode_out);
    chk("bl_ill", b == MAC_BL8 && (c == 1 || c == 4), bl_illegal_out);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    logic [45:0] e;
    cyc++;
    if (cmd_valid_out === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : '1;
      chk("cmd", e[25:23], cmd_out);
      chk("bank", e[22:20], bank_out);
      chk("addr", e[19:0], addr_out & e[45:26]);
    end
    // second parts travel with NOP, so every other command is a first part
    if (nrst_in && lk.cmd inside {MAC_READ, MAC_WRITE, MAC_AUTO_REFRESH_CMD}) begin
      chk("gap", 1, (cyc - last_t[lk.bank]) >= ((cfg_in == 4 && last_c[lk.bank] == MAC_WRITE &&
        lk.cmd == MAC_READ) ? 4 : rc_t[cfg_in]));
      last_t[lk.bank] = cyc;
      last_c[lk.bank] = lk.cmd;
    end
  end
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    #(40 * 6000);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {nrst_in, req_in, req_bank_in, req_addr_in, cfg_in, mux_m} = '0;
    req_cmd_in = MAC_NOP;
    bl_in = MAC_BL2;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    setup(1, MAC_BL2);
    issue(MAC_READ, nxt(), {nxt(), nxt()});
    issue(MAC_WRITE, nxt(), {nxt(), nxt()});
    issue(MAC_AUTO_REFRESH_CMD, 3'h1, 20'h00000);
    issue(MAC_MRS, 3'h0, 20'h00020);
    for (int c = 1; c <= 5; c++) begin
      for (int b = 0; b < 3; b++) begin
        setup(c, mac_bl_t'(b));
        if (!(b == 2 && (c == 1 || c == 4))) begin
          issue(MAC_WRITE, 3'h2, {nxt(), nxt()});
          issue(MAC_READ, 3'h2, {nxt(), nxt()});
          issue(MAC_AUTO_REFRESH_CMD, 3'h3, 20'h00000);
          issue(MAC_READ, 3'h3, {nxt(), nxt()});
          issue(MAC_WRITE, nxt(), {nxt(), nxt()});
          issue(MAC_MRS, 3'h0, 20'h00020);
        end
      end
    end
    req_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    chk("left", 20'h0, exp_q.size());
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
